// file: pkg/twm_pkg.sv
// Package: register map, field positions and constants of the two-wire master
package twm_pkg;
  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0c;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  // ==========================================
  // Field positions
  localparam int CTLA_EN_BIT = 0;
  localparam int CTLA_SMART_BIT = 1;
  localparam int CTLA_QC_BIT = 4;
  localparam int CTLB_CMD_LSB = 0;
  localparam int CTLB_ACK_BIT = 2;
  localparam int CTLB_TO_LSB = 4;
  localparam int STAT_BUS_LSB = 0;
  localparam int STAT_RXACK_BIT = 4;
  localparam int STAT_WIF_BIT = 6;
  localparam int STAT_RIF_BIT = 7;
  // ==========================================
  // Bus state field codes
  localparam logic [1:0] BUS_UNKNOWN = 2'h0;
  localparam logic [1:0] BUS_IDLE = 2'h1;
  localparam logic [1:0] BUS_OWNER = 2'h2;
  localparam logic [1:0] BUS_BUSY = 2'h3;
  // ==========================================
  // Commands in master_control_b
  localparam logic [1:0] CMD_RECV = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;
  // ==========================================
  // Reset values and timing
  localparam logic [7:0] BAUD_RST = 8'h04;
  localparam logic [1:0] ENABLE_GAP_CYCLES = 2'h2;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_HOLD, ST_RSL, ST_RSH,
    ST_XLOW, ST_XHIGH, ST_STOPL, ST_STOPH, ST_STOPR
  } twm_state_t;
endpackage

// file: hdl/twm_bus_mon.sv
// Bus monitor: pin synchronisers, start/stop detection and bus state tracking
`timescale 1ns/1ps
`default_nettype none
module twm_bus_mon (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic force_idle,
  input wire logic owner,
  input wire logic misread,
  output logic scl_s,
  output logic sda_s,
  output logic start_det,
  output logic stop_det,
  output logic [1:0] bus_state
);
  import twm_pkg::*;
  logic scl_m1_reg, scl_m2_reg, sda_m1_reg, sda_m2_reg, scl_p_reg, sda_p_reg;
  logic start_reg, stop_reg, start_next, stop_next;
  logic [1:0] bus_reg, bus_next;
  // ==========================================
  // Next state
  always_comb begin
    start_next = scl_m2_reg & scl_p_reg & sda_p_reg & ~sda_m2_reg;
    stop_next = scl_m2_reg & scl_p_reg & ~sda_p_reg & sda_m2_reg;
    bus_next = bus_reg;
    if (force_idle) begin
      bus_next = BUS_IDLE;
    end
    // Bus events win over a software force in the same cycle
    if (stop_next) begin
      bus_next = BUS_IDLE;
    end else if (start_next) begin
      bus_next = misread ? BUS_IDLE : (owner ? BUS_OWNER : BUS_BUSY);
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_m1_reg <= 1'b1;
      scl_m2_reg <= 1'b1;
      sda_m1_reg <= 1'b1;
      sda_m2_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      bus_reg <= BUS_UNKNOWN;
    end else if (ce) begin
      scl_m1_reg <= scl_in;
      scl_m2_reg <= scl_m1_reg;
      sda_m1_reg <= sda_in;
      sda_m2_reg <= sda_m1_reg;
      scl_p_reg <= scl_m2_reg;
      sda_p_reg <= sda_m2_reg;
      start_reg <= start_next;
      stop_reg <= stop_next;
      bus_reg <= bus_next;
    end
  end
  assign scl_s = scl_m2_reg;
  assign sda_s = sda_m2_reg;
  assign start_det = start_reg;
  assign stop_det = stop_reg;
  assign bus_state = bus_reg;
  // ==========================================
  // Checks
  AST_FORCE_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    ce && force_idle && !start_next && !stop_next |=> bus_reg == BUS_IDLE)
    else $error("Bus state not idle after force");
  AST_MISREAD_START: assert property (@(posedge clk) disable iff (sys_rst)
    ce && start_next && !stop_next && misread |=> bus_reg == BUS_IDLE)
    else $error("Misread start not taken as stop");
endmodule
`default_nettype wire

// file: hdl/twm_master.sv
// Two-wire bus master with APB registers and revision-specific behaviour
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Writing 0x1 to bus_state_field forces the bus monitor to idle.
// - Bus timeout field in master_control_b ignores writes and reads as zero.
// - Smart mode gives one extra SCL pulse after the master sends NACK.
// - Address write right after enabling makes the monitor take START as STOP.
// - Quick-command enable bit is unreachable; quick commands never run.
module twm_master (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe
);
  import twm_pkg::*;
  logic scl_s, sda_s, start_det, stop_det;
  logic [1:0] bus_state;
  twm_state_t state_reg, state_next;
  logic en_reg, en_next, smart_reg, smart_next, ack_act_reg, ack_act_next;
  logic rif_reg, rif_next, wif_reg, wif_next, rxack_reg, rxack_next;
  logic rx_reg, rx_next, addr_ph_reg, addr_ph_next, misread_reg, misread_next;
  logic force_reg, force_next, scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next, low_reg;
  logic [1:0] gap_reg, gap_next, cmd;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] baud_reg, baud_next, div_reg, div_next, shift_reg, shift_next, rdata_reg, rdata_next;
  logic [31:0] prdata_reg, prdata_next;
  logic wr, rd, tick, hit, txph;
  twm_bus_mon u_mon (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .force_idle(force_reg),
    .owner(state_reg != ST_IDLE),
    .misread(misread_reg),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .start_det(start_det),
    .stop_det(stop_det),
    .bus_state(bus_state)
  );
  // ==========================================
  // Next state
  always_comb begin
    wr = psel & penable & pready_reg & pwrite;
    rd = psel & penable & pready_reg & ~pwrite;
    cmd = 2'h0;
    tick = (div_reg == baud_reg);
    txph = addr_ph_reg | ~rx_reg;
    state_next = state_reg;
    en_next = en_reg;
    smart_next = smart_reg;
    ack_act_next = ack_act_reg;
    rif_next = rif_reg;
    wif_next = wif_reg;
    rxack_next = rxack_reg;
    rx_next = rx_reg;
    addr_ph_next = addr_ph_reg;
    misread_next = misread_reg & ~start_det;
    force_next = 1'b0;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    bit_next = bit_reg;
    baud_next = baud_reg;
    shift_next = shift_reg;
    rdata_next = rdata_reg;
    gap_next = (gap_reg == ENABLE_GAP_CYCLES) ? gap_reg : gap_reg + 2'h1;
    hit = (paddr == OFS_CTRL_A) | (paddr == OFS_CTRL_B) | (paddr == OFS_STATUS) |
          (paddr == OFS_BAUD) | (paddr == OFS_ADDR) | (paddr == OFS_DATA);
    pready_next = psel & ~penable;
    pslverr_next = psel & ~penable & ~hit;
    prdata_next = DATA_ZERO;
    // Read data is prepared in the setup cycle; timeout and quick-command bits read zero
    case (paddr)
      OFS_CTRL_A: prdata_next = {30'h0000_0000, smart_reg, en_reg};
      OFS_CTRL_B: prdata_next = {29'h0000_0000, ack_act_reg, 2'h0};
      OFS_STATUS: prdata_next = {24'h00_0000, rif_reg, wif_reg, 1'b0, rxack_reg, 2'h0, bus_state};
      OFS_BAUD: prdata_next = {24'h00_0000, baud_reg};
      OFS_DATA: prdata_next = {24'h00_0000, rdata_reg};
      default: prdata_next = DATA_ZERO;
    endcase
    if (wr) begin
      case (paddr)
        OFS_CTRL_A: begin
          en_next = pwdata[CTLA_EN_BIT];
          smart_next = pwdata[CTLA_SMART_BIT];
          if (pwdata[CTLA_EN_BIT] & ~en_reg) begin
            gap_next = 2'h0;
          end
        end
        OFS_CTRL_B: begin
          ack_act_next = pwdata[CTLB_ACK_BIT];
          cmd = pwdata[CTLB_CMD_LSB +: 2];
        end
        OFS_STATUS: begin
          force_next = (pwdata[STAT_BUS_LSB +: 2] == BUS_IDLE);
          if (pwdata[STAT_RIF_BIT]) begin
            rif_next = 1'b0;
          end
          if (pwdata[STAT_WIF_BIT]) begin
            wif_next = 1'b0;
          end
        end
        OFS_BAUD: baud_next = pwdata[7:0];
        OFS_ADDR: begin
          if (en_reg & gap_reg < ENABLE_GAP_CYCLES) begin
            misread_next = 1'b1;
          end
          if (en_reg & ((state_reg == ST_IDLE & bus_state == BUS_IDLE) | state_reg == ST_HOLD)) begin
            shift_next = pwdata[7:0];
            rx_next = pwdata[0];
            addr_ph_next = 1'b1;
            rif_next = 1'b0;
            wif_next = 1'b0;
            bit_next = 4'h0;
            if (state_reg == ST_IDLE) begin
              state_next = ST_START;
              sda_oe_next = 1'b1;
            end else begin
              state_next = ST_RSL;
              sda_oe_next = 1'b0;
            end
          end
        end
        OFS_DATA: begin
          if (state_reg == ST_HOLD & ~rx_reg) begin
            shift_next = pwdata[7:0];
            wif_next = 1'b0;
            bit_next = 4'h0;
            state_next = ST_LOW;
          end
        end
        default: ;
      endcase
    end
    // Smart mode: reading the data register starts the next byte
    if (rd & paddr == OFS_DATA & smart_reg & rx_reg & state_reg == ST_HOLD) begin
      cmd = CMD_RECV;
      rif_next = 1'b0;
    end
    if (state_reg == ST_HOLD & cmd == CMD_RECV & rx_reg & ~addr_ph_reg) begin
      bit_next = 4'h0;
      state_next = ST_LOW;
    end else if (state_reg == ST_HOLD & cmd == CMD_STOP) begin
      sda_oe_next = 1'b1;
      state_next = ST_STOPL;
    end
    // Clock stretching: the high phase counts only once SCL is seen high
    div_next = (tick | state_reg == ST_IDLE | state_reg == ST_HOLD) ? 8'h00 : div_reg + 8'h01;
    if (~scl_s & (state_reg == ST_HIGH | state_reg == ST_XHIGH | state_reg == ST_RSH |
                  state_reg == ST_STOPH)) begin
      div_next = 8'h00;
      tick = 1'b0;
    end
    case (state_reg)
      ST_START: if (tick) begin
        scl_oe_next = 1'b1;
        state_next = ST_LOW;
      end
      ST_LOW: begin
        sda_oe_next = (bit_reg < ACK_SLOT) ? (txph & ~shift_reg[7]) : (~txph & ~ack_act_reg);
        if (tick) begin
          scl_oe_next = 1'b0;
          state_next = ST_HIGH;
        end
      end
      ST_HIGH: if (tick) begin
        scl_oe_next = 1'b1;
        if (bit_reg < ACK_SLOT) begin
          shift_next = {shift_reg[6:0], sda_s};
          bit_next = bit_reg + 4'h1;
          state_next = ST_LOW;
        end else begin
          sda_oe_next = 1'b0;
          bit_next = 4'h0;
          state_next = ST_HOLD;
          if (txph) begin
            rxack_next = sda_s;
            addr_ph_next = 1'b0;
            if (addr_ph_reg & rx_reg & ~sda_s) begin
              state_next = ST_LOW;
            end else begin
              wif_next = 1'b1;
            end
          end else begin
            rdata_next = shift_reg;
            rif_next = 1'b1;
            if (smart_reg & ack_act_reg) begin
              state_next = ST_XLOW;
            end
          end
        end
      end
      ST_XLOW: if (tick) begin
        scl_oe_next = 1'b0;
        state_next = ST_XHIGH;
      end
      ST_XHIGH: if (tick) begin
        scl_oe_next = 1'b1;
        state_next = ST_HOLD;
      end
      ST_RSL: if (tick) begin
        scl_oe_next = 1'b0;
        state_next = ST_RSH;
      end
      ST_RSH: if (tick) begin
        sda_oe_next = 1'b1;
        state_next = ST_START;
      end
      ST_STOPL: if (tick) begin
        scl_oe_next = 1'b0;
        state_next = ST_STOPH;
      end
      ST_STOPH: if (tick) begin
        sda_oe_next = 1'b0;
        state_next = ST_STOPR;
      end
      ST_STOPR: if (tick) begin
        state_next = ST_IDLE;
      end
      default: ;
    endcase
    // Disabling drops the link at once and releases both lines
    if (~en_reg) begin
      state_next = ST_IDLE;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      {en_reg, smart_reg, ack_act_reg, rif_reg, wif_reg, rxack_reg} <= 6'h00;
      {rx_reg, addr_ph_reg, misread_reg, force_reg, scl_oe_reg, sda_oe_reg} <= 6'h00;
      {pready_reg, pslverr_reg, low_reg} <= 3'h0;
      gap_reg <= ENABLE_GAP_CYCLES;
      bit_reg <= 4'h0;
      baud_reg <= BAUD_RST;
      div_reg <= 8'h00;
      shift_reg <= 8'h00;
      rdata_reg <= 8'h00;
      prdata_reg <= DATA_ZERO;
    end else if (ce) begin
      state_reg <= state_next;
      {en_reg, smart_reg, ack_act_reg} <= {en_next, smart_next, ack_act_next};
      {rif_reg, wif_reg, rxack_reg} <= {rif_next, wif_next, rxack_next};
      {rx_reg, addr_ph_reg, misread_reg, force_reg} <= {rx_next, addr_ph_next, misread_next, force_next};
      {scl_oe_reg, sda_oe_reg} <= {scl_oe_next, sda_oe_next};
      {pready_reg, pslverr_reg} <= {pready_next, pslverr_next};
      gap_reg <= gap_next;
      bit_reg <= bit_next;
      baud_reg <= baud_next;
      div_reg <= div_next;
      shift_reg <= shift_next;
      rdata_reg <= rdata_next;
      prdata_reg <= prdata_next;
    end
  end
  // Open-drain pins: drive value is always low, only the enables move
  assign scl_out = low_reg;
  assign sda_out = low_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  // ==========================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_addr_launch;
    ce && wr && paddr == OFS_ADDR && en_reg && state_reg == ST_IDLE && bus_state == BUS_IDLE;
  endsequence
  sequence s_start_driven;
    state_reg == ST_START && sda_oe_reg && !scl_oe_reg;
  endsequence
  AST_START_FIRST: assert property (s_addr_launch |=> s_start_driven)
    else $error("Address write did not launch START");
  AST_START_THEN_LOW: assert property (ce && state_reg == ST_START && tick |=>
    state_reg == ST_LOW && scl_oe_reg && bit_reg == 4'h0 && addr_ph_reg)
    else $error("START not followed by address bits");
  AST_EXTRA_PULSE: assert property (ce && en_reg && state_reg == ST_HIGH && tick &&
    bit_reg == ACK_SLOT && !txph && smart_reg && ack_act_reg |=> state_reg == ST_XLOW ##1 scl_oe_reg)
    else $error("No extra SCL pulse after NACK");
  AST_NO_EXTRA: assert property (ce && en_reg && state_reg == ST_HIGH && tick &&
    bit_reg == ACK_SLOT && !smart_reg |=> state_reg != ST_XLOW)
    else $error("Extra pulse outside smart mode");
  AST_EARLY_ADDR: assert property (ce && wr && paddr == OFS_ADDR && en_reg &&
    gap_reg < ENABLE_GAP_CYCLES |=> misread_reg)
    else $error("Early address write not flagged");
  AST_LATE_ADDR: assert property (ce && wr && paddr == OFS_ADDR && gap_reg == ENABLE_GAP_CYCLES &&
    !misread_reg |=> !misread_reg)
    else $error("Late address write flagged");
  AST_TIMEOUT_ZERO: assert property (ce && psel && !penable && paddr == OFS_CTRL_B |=>
    prdata_reg[CTLB_TO_LSB +: 2] == 2'h0 && pready_reg)
    else $error("Timeout field readable");
  AST_QC_ZERO: assert property (ce && psel && !penable && paddr == OFS_CTRL_A |=>
    !prdata_reg[CTLA_QC_BIT] && pready_reg)
    else $error("Quick-command bit readable");
  AST_FORCE_WRITE: assert property (ce && wr && paddr == OFS_STATUS &&
    pwdata[STAT_BUS_LSB +: 2] == BUS_IDLE |=> force_reg)
    else $error("Idle force not issued");
endmodule
`default_nettype wire

// file: bench/twm_slave_model.sv
// Behavioural two-wire slave: acks its address, stores written bytes, sends tx_byte on read until the master NACKs
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_byte,
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  logic on;
  logic adr;
  logic rd;
  int k;
  // ==========================================
  // Framing
  initial begin
    sda_oe = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
    on = 1'b0;
    adr = 1'b0;
    rd = 1'b0;
    k = 0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      on = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      k = -1;
      sda_oe = 1'b0;
    end
  end
  // Released line floats to the pull-up level, never to the last bit
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      on = 1'b0;
      sda_oe = 1'b0;
    end
  end
  // ==========================================
  // Bit sampling on the rising clock
  always @(posedge scl) begin
    if (on) begin
      if (k < 8 && !(rd && !adr)) begin
        sh = {sh[6:0], sda};
      end
      // Master NACK ends our transmission; the extra pulse is ignored
      if (k == 8 && rd && !adr && sda === 1'b1) begin
        on = 1'b0;
      end
    end
  end
  // ==========================================
  // Driving on the falling clock, so data never changes while the clock is high
  always @(negedge scl) begin
    if (on) begin
      k = k + 1;
      if (k == 9) begin
        k = 0;
        sda_oe = 1'b0;
        if (adr) begin
          adr = 1'b0;
          rd = sh[0];
        end else if (!rd) begin
          rx_byte = sh;
        end
      end else if (k == 8) begin
        sda_oe = adr ? (sh[7:1] == DEV_ADDR) : !rd;
      end
      if (rd && !adr && k < 8) begin
        sda_oe = ~tx_byte[7-k];
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/twm_master_tb.sv
// Testbench: two-wire master over APB against a slave model, with an SCL pulse counter
`timescale 1ns/1ps
`default_nettype none
module twm_master_tb;
  import twm_pkg::*;
  localparam logic [6:0] SLV = 7'h2a;
  logic clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr, e;
  logic scl_out, scl_oe, sda_out, sda_oe, s_oe;
  logic [7:0] paddr, tx_byte, rx_byte, wbyte;
  logic [31:0] pwdata, prdata, q;
  wire scl_w;
  wire sda_w;
  int errors, checks_done, pulses, seed;
  logic [7:0] exp_q[$];
  // ==========================================
  // Wires, clock, instances
  assign scl_w = ~scl_oe;
  assign sda_w = ~(sda_oe | s_oe);
  always @(posedge scl_w) pulses++;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  twm_master twm_master_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe));
  twm_slave_model #(.DEV_ADDR(SLV)) twm_slave_model_inst (.scl(scl_w), .sda(sda_w), .tx_byte(tx_byte),
    .sda_oe(s_oe), .rx_byte(rx_byte));
  // ==========================================
  // Tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Leaves the bus requested so a second call gives a back-to-back transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Registered answer stands the whole access cycle; look at it mid-cycle to avoid racing the edge
    @(negedge clk);
    while (pready !== 1'b1 && k < 16) begin
      @(negedge clk);
      k++;
    end
    if (k >= 16) begin
      errors++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    @(posedge clk);
  endtask
  task automatic rel;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    rel();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    rel();
    chk(what, exp, q);
  endtask
  task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      rel();
      k++;
    end while ((q & mask) !== val && k < 400);
    if (k >= 400) begin
      errors++;
      complete_run();
    end
  endtask
  // Polling through registers is too slow to catch one pulse, so watch the wire
  task automatic wait_pulses(input int target);
    int k;
    k = 0;
    while (!(pulses >= target && scl_w === 1'b0) && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) begin
      errors++;
      complete_run();
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    seed = 94571;
    errors = 0;
    checks_done = 0;
    pulses = 0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tx_byte = 8'h00;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(OFS_CTRL_A, 32'h0000_0000, "ctrl_a reset");
    rd(OFS_BAUD, {24'h00_0000, BAUD_RST}, "baud reset");
    rd(OFS_STATUS, 32'h0000_0000, "status reset");
    apb(1'b0, 8'h20, 32'h0000_0000);
    rel();
    chk("unmapped error", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, q);
    $display("test reset done");
    wr(OFS_STATUS, 32'h0000_0001);
    rd(OFS_STATUS, {30'h0, BUS_IDLE}, "forced idle");
    wr(OFS_CTRL_B, 32'h0000_0034);
    rd(OFS_CTRL_B, 32'h0000_0004, "timeout field");
    wr(OFS_CTRL_A, 32'h0000_0013);
    rd(OFS_CTRL_A, 32'h0000_0003, "quick command bit");
    wr(OFS_BAUD, 32'h0000_0001);
    wr(OFS_CTRL_B, 32'h0000_0000);
    $display("test registers done");
    // Write: address, one byte, stop
    pulses = 0;
    wbyte = 8'($random(seed));
    exp_q.push_back(wbyte);
    wr(OFS_ADDR, {24'h00_0000, SLV, 1'b0});
    wait_stat(32'h0000_0040, 32'h0000_0040);
    chk("owner state", {30'h0, BUS_OWNER}, {30'h0, q[1:0]});
    chk("address acked", 32'h0000_0000, {31'h0, q[STAT_RXACK_BIT]});
    wr(OFS_STATUS, 32'h0000_0040);
    wr(OFS_DATA, {24'h00_0000, wbyte});
    wait_stat(32'h0000_0040, 32'h0000_0040);
    wr(OFS_CTRL_B, {30'h0, CMD_STOP});
    wait_stat(32'h0000_0003, {30'h0, BUS_IDLE});
    chk("slave byte", {24'h00_0000, exp_q.pop_front()}, {24'h00_0000, rx_byte});
    chk("write pulses", 32'(9 * 2 + 1), 32'(pulses));
    $display("test write done");
    // Read with NACK in smart mode
    tx_byte = 8'($random(seed));
    wr(OFS_CTRL_B, 32'h0000_0004);
    pulses = 0;
    wr(OFS_ADDR, {24'h00_0000, SLV, 1'b1});
    wait_stat(32'h0000_0080, 32'h0000_0080);
    wait_pulses(9 * 2 + 1);
    wr(OFS_CTRL_B, {29'h0, 1'b1, CMD_STOP});
    wait_stat(32'h0000_0003, {30'h0, BUS_IDLE});
    chk("smart nack pulses", 32'(9 * 2 + 1 + 1), 32'(pulses));
    rd(OFS_DATA, {24'h00_0000, tx_byte}, "received byte");
    $display("test smart read done");
    // Address written right after enabling
    wr(OFS_CTRL_A, 32'h0000_0000);
    wr(OFS_CTRL_B, 32'h0000_0000);
    apb(1'b1, OFS_CTRL_A, 32'h0000_0001);
    apb(1'b1, OFS_ADDR, {24'h00_0000, SLV, 1'b0});
    rel();
    wait_stat(32'h0000_0040, 32'h0000_0040);
    chk("early address state", {30'h0, BUS_IDLE}, {30'h0, q[1:0]});
    wr(OFS_CTRL_B, {30'h0, CMD_STOP});
    wait_stat(32'h0000_0003, {30'h0, BUS_IDLE});
    $display("test early address done");
    complete_run();
  end
endmodule
`default_nettype wire
